// ---- rtl/dtrs_map.vh ----
// Constants for the tone receive steering port: timing, encodings and register decode.
`ifndef DTRS_MAP_VH
`define DTRS_MAP_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define DTRS_CLK_PERIOD_NS   10
`define DTRS_SETTLE_NS       100
`define DTRS_SETTLE_CYC      ((`DTRS_SETTLE_NS + `DTRS_CLK_PERIOD_NS - 1) / `DTRS_CLK_PERIOD_NS)
`define DTRS_CNT_W           16
`define DTRS_GUARD_DEF       16'h0400
`define DTRS_PERIOD_W        17
`define DTRS_MATCH_NEED      4'h4
`define DTRS_TOL             17'h00100
// Past the longest half period plus tolerance no tone can match, so the
// comparator is taken as stalled and the tone as gone.
`define DTRS_STALL_CYC       17'h11A00

// ----------------------------------------------------------------------------
// Tone half-periods in 10 ns cycles (low group then high group).
// The slowest low tone needs 17 bits at this clock rate.
// ----------------------------------------------------------------------------
`define DTRS_LO0             17'h11838
`define DTRS_LO1             17'h0FDA7
`define DTRS_LO2             17'h0E53D
`define DTRS_LO3             17'h0CF8F
`define DTRS_HI0             17'h0A18D
`define DTRS_HI1             17'h09231
`define DTRS_HI2             17'h0843C
`define DTRS_HI3             17'h0779B

// ----------------------------------------------------------------------------
// Register decode: reg_select values and status bit positions.
// ----------------------------------------------------------------------------
`define DTRS_RS_DATA         1'b0
`define DTRS_RS_CTRL         1'b1
`define DTRS_STAT_IRQ_BIT    0
`define DTRS_STAT_DS_BIT     2

`endif

// ---- rtl/dtrs_receiver.v ----
// Receive side of a tone transceiver: detector, steering, digit latch and 4-bit MPU port.
// Overview of operation
// - Early steer high while tone pair valid, except in call-progress mode.
// - Count comparator half periods, accept standard tones.
// - Steer input high registers the 4-bit code.
// - Guard output follows early steer after registration.
// - Absent guard expiry after tone loss frees for new pair.
// - Delayed steer flag after short settling delay.
// - Delayed steer flag readable in status.
// - Interrupt mode pulls pin low on flag.
// - Output latch updates on delayed steer rising.
// - Data read drives latched digit on bus.
// - Bus released when select high or phase low.
// - Call-progress mode with interrupt enabled squares input onto pin.
// - Guard timing rejects short tones and dropouts.
// - One status, two control, two data registers.
// - Register select and direction decode registers.
// - Digits use the standard 4-bit encode table.
`timescale 1ns/1ps
`include "dtrs_map.vh"

module dtrs_receiver
(
	input  wire        sys_clk,             // System clock, 100 MHz.
	input  wire        srst,                // Synchronous reset, active high.
	input  wire        low_sq,              // Low-group comparator output.
	input  wire        high_sq,             // High-group comparator output.
	input  wire        cp_sq,               // Call-progress comparator output.
	input  wire [15:0] tone_present_guard,  // Guard cycles for tone present.
	input  wire [15:0] tone_absent_guard,   // Guard cycles for tone absent.
	input  wire        steer_in_guard_in,   // Steer pin level above threshold.
	output reg         steer_in_guard_out,  // Guard output drive level.
	output reg         steer_in_guard_oe_n, // Guard pin drive enable, low drives.
	output reg         early_steer_out,     // Early steering output.
	input  wire        cs_n,                // Chip select, active low.
	input  wire        phase_clk,           // Bus phase clock level.
	input  wire        reg_select,          // Register select.
	input  wire        rd_wr,               // High reads, low writes.
	input  wire [3:0]  data_bus_4b_in,      // Data bus input.
	output reg  [3:0]  data_bus_4b_out,     // Data bus output.
	output reg         data_bus_4b_oe_n,    // Data bus drive enable, low drives.
	output reg         irq_callprog_pin_oe_n, // Open-drain pull, low pulls pin low.
	output reg         irq_callprog_level,  // Square wave level in call-progress mode with interrupt enabled.
	output reg         delayed_steer,       // Delayed steering flag.
	output reg  [3:0]  tx_data,             // Transmit data register.
	output reg  [3:0]  ctrl_a,              // Control register A.
	output reg  [3:0]  ctrl_b               // Control register B.
);

	// ------------------------------------------------------------------------
	// Control bit positions within control register A.
	// ------------------------------------------------------------------------
	localparam IRQ_EN_BIT = 2;               // Interrupt enable.
	localparam CP_BIT     = 0;               // call_progress_mode select.
	localparam CRB_SEL    = 3;               // Next control write goes to B.

	// Steering state machine.
	localparam ST_IDLE = 2'h0;               // Waiting for a tone.
	localparam ST_GUARD = 2'h1;              // Tone present, guarding.
	localparam ST_HELD = 2'h2;               // Registered, waiting for release.
	localparam ST_GAP = 2'h3;                // Tone gone, guarding pause.

	wire        lo_ok;                       // Low tone confirmed.
	wire [1:0]  lo_idx;                      // Low tone row.
	wire        hi_ok;                       // High tone confirmed.
	wire [1:0]  hi_idx;                      // High tone column.
	reg  [1:0]  state;                       // Steering state.
	reg  [15:0] guard_cnt;                   // Steering time-constant model.
	reg  [3:0]  code_hold;                   // Registered code before latch.
	reg  [3:0]  rx_latch;                    // Receive data output latch.
	reg  [7:0]  settle_cnt;                  // Settling delay counter.
	reg         settling;                    // Settling in progress.
	reg         ds_q;                        // Previous delayed steer.
	reg         phase_q;                     // Previous phase level.
	wire        call_progress_mode;          // Call-progress selected.
	wire        irq_en;                      // Interrupt enabled.
	wire        bus_sel;                     // Bus cycle active.
	wire        acc_end;                     // Falling edge of phase.

	assign call_progress_mode = ctrl_a[CP_BIT];
	assign irq_en = ctrl_a[IRQ_EN_BIT];
	assign bus_sel = !cs_n && phase_clk;
	assign acc_end = phase_q && !phase_clk && !cs_n;

	// ------------------------------------------------------------------------
	// Tone encode: row and column to digit code.
	// ------------------------------------------------------------------------
	// digit encode table
	function [3:0] encode;
		input [1:0] row;
		input [1:0] col;
		begin
			if (col == 2'h3)
				encode = (row == 2'h3) ? 4'h0 : {2'h3, row + 2'h1};
			else if (row == 2'h3)
				encode = (col == 2'h0) ? 4'hB : ((col == 2'h1) ? 4'hA : 4'hC);
			else
				encode = {row, 2'h0} - {2'h0, row} + {2'h0, col} + 4'h1;
		end
	endfunction

	dtrs_tone_meas #(.HALF_TABLE({`DTRS_LO3, `DTRS_LO2, `DTRS_LO1, `DTRS_LO0})) u_lo
	(
		.sys_clk (sys_clk),
		.srst    (srst),
		.sq_in   (low_sq),
		.valid   (lo_ok),
		.index   (lo_idx)
	);

	dtrs_tone_meas #(.HALF_TABLE({`DTRS_HI3, `DTRS_HI2, `DTRS_HI1, `DTRS_HI0})) u_hi
	(
		.sys_clk (sys_clk),
		.srst    (srst),
		.sq_in   (high_sq),
		.valid   (hi_ok),
		.index   (hi_idx)
	);

	// ------------------------------------------------------------------------
	// Early steering and steering state machine.
	// ------------------------------------------------------------------------
	// Detection is suppressed in call-progress mode because the input is
	// routed through the call-progress filter instead.
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			early_steer_out <= 1'b0;
			state <= ST_IDLE;
			guard_cnt <= 16'h0000;
			code_hold <= 4'h0;
			steer_in_guard_out <= 1'b0;
			steer_in_guard_oe_n <= 1'b1;
			settling <= 1'b0;
			settle_cnt <= 8'h00;
			delayed_steer <= 1'b0;
		end
		else
		begin
			early_steer_out <= lo_ok && hi_ok && !call_progress_mode;
			// guard after registration
			// Driving high only once registered keeps the pin from cutting the
			// tone-present guard short.
			steer_in_guard_out <= early_steer_out && (state == ST_HELD || state == ST_GAP);
			steer_in_guard_oe_n <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					guard_cnt <= 16'h0000;
					if (early_steer_out)
						state <= ST_GUARD;
				end
				ST_GUARD:
				begin
					if (!early_steer_out)
						state <= ST_IDLE;
					else if (guard_cnt >= tone_present_guard || steer_in_guard_in)
					begin
						code_hold <= encode(lo_idx, hi_idx);
						settling <= 1'b1;
						settle_cnt <= 8'h00;
						state <= ST_HELD;
					end
					else
						guard_cnt <= guard_cnt + 16'h0001;
				end
				ST_HELD:
				begin
					guard_cnt <= 16'h0000;
					if (!early_steer_out)
						state <= ST_GAP;
				end
				ST_GAP:
				begin
					if (early_steer_out)
						state <= ST_HELD;
					else if (guard_cnt >= tone_absent_guard)
					begin
						delayed_steer <= 1'b0;
						state <= ST_IDLE;
					end
					else
						guard_cnt <= guard_cnt + 16'h0001;
				end
				default:
					state <= ST_IDLE;
			endcase
			if (settling)
			begin
				if (settle_cnt == `DTRS_SETTLE_CYC - 1)
				begin
					settling <= 1'b0;
					delayed_steer <= 1'b1;
				end
				else
					settle_cnt <= settle_cnt + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Output latch, registers and bus port.
	// ------------------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			ds_q <= 1'b0;
			rx_latch <= 4'h0;
			phase_q <= 1'b0;
			tx_data <= 4'h0;
			ctrl_a <= 4'h0;
			ctrl_b <= 4'h0;
			data_bus_4b_out <= 4'h0;
			data_bus_4b_oe_n <= 1'b1;
			irq_callprog_pin_oe_n <= 1'b1;
			irq_callprog_level <= 1'b0;
		end
		else
		begin
			ds_q <= delayed_steer;
			phase_q <= phase_clk;
			if (delayed_steer && !ds_q)
				rx_latch <= code_hold;
			data_bus_4b_oe_n <= !(bus_sel && rd_wr);
			if (reg_select == `DTRS_RS_DATA)
				data_bus_4b_out <= rx_latch;
			else
				data_bus_4b_out <= {1'b0, delayed_steer, 1'b0, delayed_steer && irq_en};
			if (acc_end && !rd_wr)
			begin
				if (reg_select == `DTRS_RS_DATA)
					tx_data <= data_bus_4b_in;
				else if (ctrl_a[CRB_SEL])
				begin
					ctrl_b <= data_bus_4b_in;
					ctrl_a[CRB_SEL] <= 1'b0;
				end
				else
					ctrl_a <= data_bus_4b_in;
			end
			irq_callprog_level <= call_progress_mode && irq_en && cp_sq;
			irq_callprog_pin_oe_n <= !(irq_en &&
				(call_progress_mode ? !cp_sq : delayed_steer));
		end
	end

endmodule

// ---- rtl/dtrs_tone_meas.v ----
// Measures one comparator square wave and reports which of four tones it matches.
`timescale 1ns/1ps
`include "dtrs_map.vh"

module dtrs_tone_meas
#(
	parameter [67:0] HALF_TABLE = 68'h0    // Four 17-bit nominal half periods.
)
(
	input  wire       sys_clk,   // System clock.
	input  wire       srst,      // Synchronous reset, active high.
	input  wire       sq_in,     // Comparator square wave.
	output reg        valid,     // A tone has matched steadily.
	output reg  [1:0] index      // Which of the four tones.
);

	reg  [16:0] run_cnt;     // Cycles since last edge.
	reg         sq_q;        // Previous input level.
	reg  [1:0]  last_idx;    // Tone matched by the last half period.
	reg  [3:0]  streak;      // Consecutive matching half periods.

	// ------------------------------------------------------------------------
	// Tolerant match against one nominal half period.
	// ------------------------------------------------------------------------
	function near;
		input [16:0] meas;
		input [16:0] nom;
		begin
			near = (meas + `DTRS_TOL >= nom) && (meas <= nom + `DTRS_TOL);
		end
	endfunction

	reg        hit;
	reg  [1:0] hit_idx;
	integer    k;

	// Comparing against all four tones at once keeps the decision to one cycle.
	always @*
	begin
		hit = 1'b0;
		hit_idx = 2'h0;
		for (k = 0; k < 4; k = k + 1)
		begin
			if (near(run_cnt, HALF_TABLE[k*17 +: 17]))
			begin
				hit = 1'b1;
				hit_idx = k[1:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Count between edges; several agreeing half periods confirm the tone.
	// ------------------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			run_cnt <= 17'h00000;
			sq_q <= 1'b0;
			last_idx <= 2'h0;
			streak <= 4'h0;
			valid <= 1'b0;
			index <= 2'h0;
		end
		else
		begin
			sq_q <= sq_in;
			if (sq_in != sq_q)
			begin
				// An edge ends a half period.
				run_cnt <= 17'h00000;
				if (hit && (hit_idx == last_idx || streak == 4'h0))
				begin
					if (streak != `DTRS_MATCH_NEED)
						streak <= streak + 4'h1;
					last_idx <= hit_idx;
					valid <= (streak + 4'h1 >= `DTRS_MATCH_NEED);
					index <= hit_idx;
				end
				else
				begin
					// Any off-frequency half period drops the tone at once.
					streak <= 4'h0;
					valid <= 1'b0;
				end
			end
			else if (run_cnt >= `DTRS_STALL_CYC)
			begin
				// Input stalled: no tone.
				streak <= 4'h0;
				valid <= 1'b0;
			end
			else
			begin
				run_cnt <= run_cnt + 17'h00001;
			end
		end
	end

endmodule

// ---- sim/dtrs_mpu_model.sv ----
// Behavioural processor on the 4-bit bus of the steering port.
`timescale 1ns/1ps

module dtrs_mpu_model
(
	input  wire       sys_clk,          // Clock.
	output reg        cs_n,             // Chip select.
	output reg        phase_clk,        // Bus phase.
	output reg        reg_select,       // Register select.
	output reg        rd_wr,            // Direction, high reads.
	output wire [3:0] data_bus_4b_in,   // Resolved bus level.
	input  wire [3:0] data_bus_4b_out,  // Device drive value.
	input  wire       data_bus_4b_oe_n  // Device enable, low drives.
);

reg [3:0] mpu_d;     // Write data.
reg       mpu_drive; // Processor drives bus.
reg [3:0] last;      // Last bus level.

// An undriven bus shows a changing pattern so a missed drive never reads as a match.
assign data_bus_4b_in = !data_bus_4b_oe_n ? data_bus_4b_out : (mpu_drive ? mpu_d : ~last);

always @(posedge sys_clk)
	last <= data_bus_4b_in;

initial
begin
	cs_n = 1'b1;
	phase_clk = 1'b0;
	reg_select = 1'b0;
	rd_wr = 1'b1;
	mpu_d = 4'h0;
	mpu_drive = 1'b0;
	last = 4'h0;
end

task wr(input sel_n, input rs, input [3:0] d);
begin
	@(negedge sys_clk);
	cs_n = sel_n;
	rd_wr = 1'b0;
	reg_select = rs;
	mpu_d = d;
	mpu_drive = 1'b1;
	phase_clk = 1'b1;
	@(negedge sys_clk);
	phase_clk = 1'b0;
	@(negedge sys_clk);
	cs_n = 1'b1;
	mpu_drive = 1'b0;
	rd_wr = 1'b1;
end
endtask

task rd(input rs, output [3:0] d);
	integer k;
begin
	@(negedge sys_clk);
	cs_n = 1'b0;
	rd_wr = 1'b1;
	reg_select = rs;
	phase_clk = 1'b1;
	k = 0;
	do
	begin
		@(posedge sys_clk);
		k = k + 1;
	end
	while (data_bus_4b_oe_n && k < 4);
	d = data_bus_4b_in;
	@(negedge sys_clk);
	phase_clk = 1'b0;
	cs_n = 1'b1;
end
endtask

endmodule

// ---- sim/dtrs_receiver_tb_top.sv ----
// Self-checking bench for the tone receive steering port.
`timescale 1ns/1ps
`include "dtrs_map.vh"

`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end

module dtrs_receiver_tb_top;

reg        sys_clk, srst, low_sq, high_sq, cp_sq, tone_on, steer_in; // Stimulus.
integer    n_fail, checked, cyc, lc, hc, i;                // Counters.
reg  [3:0] rdv;                                            // Read value.
wire       cs_n, phase_clk, reg_select, rd_wr;             // Bus control.
wire [3:0] bus_in, bus_out, tx_data, ctrl_a, ctrl_b;       // Bus and registers.
wire       bus_oe_n, g_out, g_oe_n, early, irq_oe_n, irq_lvl, dly; // Outputs.

dtrs_receiver uut (.sys_clk(sys_clk), .srst(srst), .low_sq(low_sq), .high_sq(high_sq),
	.cp_sq(cp_sq), .tone_present_guard(16'h0400), .tone_absent_guard(16'h0014),
	.steer_in_guard_in(steer_in), .steer_in_guard_out(g_out), .steer_in_guard_oe_n(g_oe_n),
	.early_steer_out(early), .cs_n(cs_n), .phase_clk(phase_clk), .reg_select(reg_select),
	.rd_wr(rd_wr), .data_bus_4b_in(bus_in), .data_bus_4b_out(bus_out),
	.data_bus_4b_oe_n(bus_oe_n), .irq_callprog_pin_oe_n(irq_oe_n),
	.irq_callprog_level(irq_lvl), .delayed_steer(dly), .tx_data(tx_data),
	.ctrl_a(ctrl_a), .ctrl_b(ctrl_b));

dtrs_mpu_model mpu (.sys_clk(sys_clk), .cs_n(cs_n), .phase_clk(phase_clk),
	.reg_select(reg_select), .rd_wr(rd_wr), .data_bus_4b_in(bus_in),
	.data_bus_4b_out(bus_out), .data_bus_4b_oe_n(bus_oe_n));

// Clock of 10 ns period.
initial
begin
	sys_clk = 1'b0;
	forever #5 sys_clk = ~sys_clk;
end

// Square waves of the 941 and 1477 tones, giving the hash digit.
always @(negedge sys_clk)
begin
	if (tone_on)
	begin
		lc = (lc == `DTRS_LO3 - 1) ? 0 : lc + 1;
		hc = (hc == `DTRS_HI2 - 1) ? 0 : hc + 1;
		if (lc == 0)
			low_sq = ~low_sq;
		if (hc == 0)
			high_sq = ~high_sq;
	end
end

// Ceiling: four slow half periods to detect, one stall time to lose, plus bus traffic.
always @(posedge sys_clk)
begin
	cyc = cyc + 1;
	if (cyc == 320000)
	begin
		n_fail = n_fail + 1;
		test_done;
	end
end

task test_done;
begin
	$display("checked=%0d n_fail=%0d", checked, n_fail);
	if (n_fail == 0 && checked > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
end
endtask

// ----------------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------------
initial
begin
	n_fail = 0; checked = 0; cyc = 0; lc = 0; hc = 0; steer_in = 1'b0;
	low_sq = 1'b0; high_sq = 1'b0; cp_sq = 1'b0; tone_on = 1'b0; srst = 1'b1;
	repeat (2) @(negedge sys_clk);
	srst = 1'b0;
	@(negedge sys_clk);
	`CHK(bus_oe_n, 1'b1);
	`CHK(dly, 1'b0);
	// Selector bit sends the second control write to B; the refused write must not land.
	mpu.wr(0, 1, 4'hC);
	mpu.wr(0, 1, 4'h5);
	mpu.wr(0, 1, 4'h4);
	mpu.wr(0, 0, 4'h9);
	mpu.wr(1, 0, 4'hA);
	`CHK(ctrl_b, 4'h5);
	`CHK(ctrl_a, 4'h4);
	`CHK(tx_data, 4'h9);
	mpu.rd(1, rdv);
	`CHK(rdv, 4'h0);
	tone_on = 1'b1;
	for (i = 0; i < 250000 && early !== 1'b1; i = i + 1) @(negedge sys_clk);
	`CHK(early, 1'b1);
	// The present guard outlasts this whole wait, so only the steer input can register.
	repeat (3) @(negedge sys_clk);
	`CHK(dly, 1'b0);
	`CHK(g_out, 1'b0);
	steer_in = 1'b1;
	repeat (5) @(negedge sys_clk);
	`CHK(dly, 1'b0);
	for (i = 0; i < 16 && dly !== 1'b1; i = i + 1) @(negedge sys_clk);
	`CHK(dly, 1'b1);
	steer_in = 1'b0;
	@(negedge sys_clk);
	`CHK(g_out, 1'b1);
	`CHK(irq_oe_n, 1'b0);
	mpu.rd(0, rdv);
	`CHK(rdv, 4'hC);
	mpu.rd(1, rdv);
	`CHK(rdv, 4'h5);
	// Tone removed: flag must outlast the loss for the absent guard, then clear.
	tone_on = 1'b0;
	for (i = 0; i < 100000 && early !== 1'b0; i = i + 1) @(negedge sys_clk);
	`CHK(early, 1'b0);
	`CHK(dly, 1'b1);
	for (i = 0; i < 200 && dly !== 1'b0; i = i + 1) @(negedge sys_clk);
	`CHK(dly, 1'b0);
	@(negedge sys_clk);
	`CHK(irq_oe_n, 1'b1);
	`CHK(g_out, 1'b0);
	mpu.rd(0, rdv);
	`CHK(rdv, 4'hC);
	mpu.wr(0, 1, 4'h5);
	// The released open-drain pin reads high, so the pull tracks the low phases.
	repeat (4)
	begin
		@(negedge sys_clk);
		cp_sq = ~cp_sq;
		repeat (2) @(negedge sys_clk);
		`CHK(irq_lvl, cp_sq);
		`CHK(irq_oe_n, cp_sq);
	end
	test_done;
end

endmodule

bind dtrs_receiver dtrs_rx_assertions chk (.sys_clk(sys_clk), .srst(srst), .cp_sq(cp_sq),
	.cs_n(cs_n), .phase_clk(phase_clk), .reg_select(reg_select), .rd_wr(rd_wr),
	.data_bus_4b_out(data_bus_4b_out), .data_bus_4b_oe_n(data_bus_4b_oe_n),
	.irq_callprog_pin_oe_n(irq_callprog_pin_oe_n), .irq_callprog_level(irq_callprog_level),
	.delayed_steer(delayed_steer), .early_steer_out(early_steer_out),
	.steer_in_guard_out(steer_in_guard_out), .steer_in_guard_oe_n(steer_in_guard_oe_n),
	.ctrl_a(ctrl_a));

// ---- sim/dtrs_rx_assertions.sv ----
// Concurrent checks on the tone receive steering port.
`timescale 1ns/1ps

module dtrs_rx_assertions
(
	input wire       sys_clk,               // Clock.
	input wire       srst,                  // Reset.
	input wire       cp_sq,                 // Call-progress square.
	input wire       cs_n,                  // Chip select.
	input wire       phase_clk,             // Bus phase.
	input wire       reg_select,            // Register select.
	input wire       rd_wr,                 // Direction.
	input wire [3:0] data_bus_4b_out,       // Bus drive value.
	input wire       data_bus_4b_oe_n,      // Bus enable.
	input wire       irq_callprog_pin_oe_n, // Pin pull.
	input wire       irq_callprog_level,    // Square level.
	input wire       delayed_steer,         // Digit flag.
	input wire       early_steer_out,       // Early steer.
	input wire       steer_in_guard_out,    // Guard level.
	input wire       steer_in_guard_oe_n,   // Guard enable.
	input wire [3:0] ctrl_a                 // Control A.
);

// ----------------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------------
// All checks share one clock; reset disables them since outputs are forced then.
default clocking cb @(posedge sys_clk); endclocking
default disable iff (srst);

a_bus_release: assert property ((cs_n || !phase_clk) |=> data_bus_4b_oe_n)
	else $error("bus driven while unselected");
a_read_drive: assert property ((!cs_n && phase_clk && rd_wr) |=> !data_bus_4b_oe_n)
	else $error("read not driven");
a_status_bit: assert property ((!cs_n && phase_clk && rd_wr && reg_select)
	|=> data_bus_4b_out[2] == $past(delayed_steer)) else $error("status flag bit wrong");
a_irq_pull: assert property ((ctrl_a[2] && !ctrl_a[0])
	|=> irq_callprog_pin_oe_n == !$past(delayed_steer)) else $error("irq pull wrong");
// The open-drain pin reads high when released, so the pull follows the low phases.
a_cp_square: assert property ((ctrl_a[2] && ctrl_a[0]) |=>
	irq_callprog_level == $past(cp_sq) && irq_callprog_pin_oe_n == $past(cp_sq))
	else $error("call-progress copy wrong");
a_cp_quiet: assert property (ctrl_a[0] [*2] |-> !early_steer_out)
	else $error("early steer in call-progress mode");
a_guard_drop: assert property ($fell(early_steer_out) |=> !steer_in_guard_out)
	else $error("guard held after early steer fell");
a_guard_drive: assert property (!$past(srst) |-> !steer_in_guard_oe_n)
	else $error("guard pin not driven");
a_short_reject: assert property ((!delayed_steer && $rose(early_steer_out))
	|-> !delayed_steer [*8]) else $error("flag raised too early");
a_free_absent: assert property ($fell(delayed_steer) |-> !early_steer_out)
	else $error("flag cleared with tone present");

c_digit: cover property ($rose(delayed_steer));
c_stat_rd: cover property (!cs_n && phase_clk && rd_wr && reg_select);
c_cp_wave: cover property (ctrl_a[0] && $rose(irq_callprog_level));

endmodule
